// *** rtl/omr_pkg.sv ***
// Constants and types shared by the operating mode register block.
package omr_pkg;

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    localparam int DATA_W = 24;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_MODE_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_STOP_STATUS = 4'h3;

    // ------------------------------------------------------------------
    // Field positions of operating_mode_control
    // ------------------------------------------------------------------
    localparam int CHIP_MODE_LSB = 0;
    localparam int CHIP_MODE_W = 4;
    localparam int EXT_BUS_OFF_BIT = 4;
    localparam int STOP_WAIT_SHORT_BIT = 6;
    localparam int MEM_SWAP_ON_BIT = 7;
    localparam int CORE_DMA_PRIO_LSB = 8;
    localparam int CORE_DMA_PRIO_W = 2;
    localparam int BURST_ON_BIT = 10;
    localparam int ACK_SYNC_SEL_BIT = 11;
    localparam int RELEASE_SLOW_BIT = 12;
    localparam int ASYNC_ARB_ON_BIT = 13;
    localparam int STACK_EXT_SPACE_BIT = 16;
    localparam int STACK_EXT_OVER_BIT = 18;
    localparam int STACK_EXT_WRAPPED_BIT = 19;
    localparam int STACK_EXT_ON_BIT = 20;

    // Bits that store what software writes; all others read as zero except flag bits 18 and 19.
    localparam logic [DATA_W-1:0] CTRL_WRITE_MASK = 24'h113fdf;
    localparam logic [DATA_W-1:0] CTRL_RESET = 24'h000000;

    // ------------------------------------------------------------------
    // Interrupt status bits
    // ------------------------------------------------------------------
    localparam int IRQ_W = 3;
    localparam int IRQ_OVER_BIT = 0;
    localparam int IRQ_WRAP_BIT = 1;
    localparam int IRQ_STOP_DONE_BIT = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

    // ------------------------------------------------------------------
    // Stop recovery delay, in core clock cycles
    // ------------------------------------------------------------------
    localparam int STOP_CNT_W = 18;
    localparam int STOP_WAIT_LONG_CYC = 131072;
    localparam logic [STOP_CNT_W-1:0] STOP_WAIT_SHORT_CYC = 18'h00010;

    // ------------------------------------------------------------------
    // Core versus DMA priority encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PRIO_COMPARE = 2'h0,
        PRIO_DMA_HIGHER = 2'h1,
        PRIO_DMA_EQUAL = 2'h2,
        PRIO_DMA_LOWER = 2'h3
    } core_dma_prio_t;

    typedef enum logic {
        STOP_IDLE,
        STOP_WAIT
    } stop_state_t;

endpackage

// *** rtl/operating_mode_register.sv ***
// Operating mode register with stack flags, stop delay and bus arbitration.
//
// How it works
// RQ1 - Bits 3 to 0 hold the chip operating mode and drive the mode output.
// RQ2 - Bit 4 set turns the external bus off, clear leaves it on.
// RQ3 - Leaving stop waits 128K cycles with bit 6 clear, 16 cycles with it set.
// RQ4 - Bit 7 set enables memory switching, clear disables it.
// RQ5 - Bits 9 to 8 pick a priority behaviour, one comparing core and channel.
// RQ6 - The other codes make DMA higher, equal or lower than the core.
// RQ7 - Bit 10 enables the bus burst mode while set.
// RQ8 - Bit 11 picks the transfer acknowledge pin raw or synchronised.
// RQ9 - Bit 12 clear gives fast bus release, set gives slow release.
// RQ10 - Bit 13 set allows asynchronous bus arbitration, clear keeps it sync.
// RQ11 - Bit 18 is set on a stack extension overflow and stays until cleared.
// RQ12 - Bit 19 is set on a stack extension wrap and stays until cleared.
// RQ13 - Bit 20 enables the stack extension in memory while set.
// RQ14 - Bit 16 places the stack extension in X memory when clear, Y when set.
// RQ15 - Priority codes are 00 compare, 01 higher, 10 equal, 11 lower.
// RQ16 - Control fields read back as written, reserved bits read zero.
`timescale 1ns/1ps
`default_nettype none

module operating_mode_register
    import omr_pkg::*;
#(
    parameter int STOP_WAIT_LONG = STOP_WAIT_LONG_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    input wire logic stack_over_evt_i,
    input wire logic stack_wrap_evt_i,
    input wire logic stop_exit_i,
    input wire logic ta_n_i,
    input wire logic [1:0] core_prio_field_i,
    input wire logic [1:0] dma_chan_prio_i,
    input wire logic dma_req_i,
    input wire logic core_req_i,
    output logic [CHIP_MODE_W-1:0] chip_mode_o,
    output logic ext_bus_off_o,
    output logic mem_swap_on_o,
    output logic burst_on_o,
    output logic release_slow_o,
    output logic async_arb_on_o,
    output logic stack_ext_on_o,
    output logic stack_ext_space_o,
    output logic stack_ext_over_o,
    output logic stack_ext_wrapped_o,
    output logic stop_busy_o,
    output logic stop_done_o,
    output logic ta_o,
    output logic dma_grant_o,
    output logic irq_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] ctrl;
        logic [IRQ_W-1:0] irq_mask;
        logic [DATA_W-1:0] rdata;
        logic ta_meta;
        logic ta_sync;
        logic ta;
        stop_state_t stop_state;
        logic [STOP_CNT_W-1:0] stop_cnt;
        logic stop_done;
        logic dma_grant;
        logic equal_turn_dma;
        logic irq;
    } omr_state_t;

    omr_state_t st;
    omr_state_t next_st;

    logic over_flag;
    logic wrap_flag;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic ctrl_wr;
    logic over_clr;
    logic wrap_clr;
    logic stop_done_evt;

    localparam logic [STOP_CNT_W-1:0] STOP_LONG_LOAD =
        STOP_CNT_W'(STOP_WAIT_LONG);

    // ------------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------------
    // Writing zero to a flag position of the control register clears it.
    assign ctrl_wr = wr_i && (addr_i == ADDR_MODE_CTRL);
    assign over_clr = ctrl_wr && !wdata_i[STACK_EXT_OVER_BIT];
    assign wrap_clr = ctrl_wr && !wdata_i[STACK_EXT_WRAPPED_BIT];

    sticky_flag u_over_flag (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .set_i(stack_over_evt_i), // RQ11
        .clr_i(over_clr),
        .q_o(over_flag)
    );

    sticky_flag u_wrap_flag (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .set_i(stack_wrap_evt_i), // RQ12
        .clr_i(wrap_clr),
        .q_o(wrap_flag)
    );

    // ------------------------------------------------------------------
    // Interrupt status, write one to clear
    // ------------------------------------------------------------------
    assign stop_done_evt = (st.stop_state == STOP_WAIT) &&
                           (st.stop_cnt == '0);

    always_comb begin
        irq_set = '0;
        irq_set[IRQ_OVER_BIT] = stack_over_evt_i;
        irq_set[IRQ_WRAP_BIT] = stack_wrap_evt_i;
        irq_set[IRQ_STOP_DONE_BIT] = stop_done_evt;
        irq_clr = '0;
        if (wr_i && (addr_i == ADDR_IRQ_STATUS)) begin
            irq_clr = wdata_i[IRQ_W-1:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
            sticky_flag u_irq_flag (
                .ref_clk_i(ref_clk_i),
                .rst_n_i(rst_n_i),
                .set_i(irq_set[gi]),
                .clr_i(irq_clr[gi]),
                .q_o(irq_status[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [DATA_W-1:0] ctrl_view;
        core_dma_prio_t prio;
        ctrl_view = '0;
        prio = PRIO_COMPARE;
        next_st = st;

        // Control register write keeps only the defined bits.
        if (ctrl_wr) begin
            next_st.ctrl = wdata_i & CTRL_WRITE_MASK; // RQ16
        end
        if (wr_i && (addr_i == ADDR_IRQ_MASK)) begin
            next_st.irq_mask = wdata_i[IRQ_W-1:0];
        end

        // Read data stand in the cycle after the read strobe only.
        ctrl_view = st.ctrl & CTRL_WRITE_MASK; // RQ16
        ctrl_view[STACK_EXT_OVER_BIT] = over_flag; // RQ11
        ctrl_view[STACK_EXT_WRAPPED_BIT] = wrap_flag; // RQ12
        next_st.rdata = '0;
        if (rd_i) begin
            case (addr_i)
                ADDR_MODE_CTRL: begin
                    next_st.rdata = ctrl_view;
                end
                ADDR_IRQ_STATUS: begin
                    next_st.rdata[IRQ_W-1:0] = irq_status;
                end
                ADDR_IRQ_MASK: begin
                    next_st.rdata[IRQ_W-1:0] = st.irq_mask;
                end
                ADDR_STOP_STATUS: begin
                    next_st.rdata[STOP_CNT_W-1:0] = st.stop_cnt;
                    next_st.rdata[DATA_W-1] = (st.stop_state == STOP_WAIT);
                end
                default: begin
                    next_st.rdata = '0;
                end
            endcase
        end

        // Transfer acknowledge: raw pin or two-stage synchronised pin.
        // The raw path takes the pin into one flop, so its setup time is
        // the user's concern; the synchronised path costs two more cycles.
        next_st.ta_meta = ta_n_i;
        next_st.ta_sync = st.ta_meta;
        if (st.ctrl[ACK_SYNC_SEL_BIT]) begin
            next_st.ta = !st.ta_sync; // RQ8
        end else begin
            next_st.ta = !ta_n_i; // RQ8
        end

        // Stop recovery delay counter.
        next_st.stop_done = 1'b0;
        case (st.stop_state)
            STOP_IDLE: begin
                if (stop_exit_i) begin
                    next_st.stop_state = STOP_WAIT;
                    if (st.ctrl[STOP_WAIT_SHORT_BIT]) begin
                        next_st.stop_cnt = STOP_WAIT_SHORT_CYC - 1'b1; // RQ3
                    end else begin
                        next_st.stop_cnt = STOP_LONG_LOAD - 1'b1; // RQ3
                    end
                end
            end
            STOP_WAIT: begin
                if (st.stop_cnt == '0) begin
                    next_st.stop_state = STOP_IDLE;
                    next_st.stop_done = 1'b1;
                end else begin
                    next_st.stop_cnt = st.stop_cnt - 1'b1;
                end
            end
            default: begin
                next_st.stop_state = STOP_IDLE;
                next_st.stop_cnt = '0;
            end
        endcase

        // Core versus DMA arbitration.
        prio = core_dma_prio_t'(st.ctrl[CORE_DMA_PRIO_LSB +:
                                        CORE_DMA_PRIO_W]); // RQ5
        next_st.dma_grant = 1'b0;
        case (prio)
            PRIO_COMPARE: begin
                next_st.dma_grant = dma_req_i &&
                    (!core_req_i ||
                     (dma_chan_prio_i > core_prio_field_i)); // RQ5 RQ15
            end
            PRIO_DMA_HIGHER: begin
                next_st.dma_grant = dma_req_i; // RQ6 RQ15
            end
            PRIO_DMA_EQUAL: begin
                // Equal standing alternates when both want the bus.
                if (dma_req_i && core_req_i) begin
                    next_st.dma_grant = st.equal_turn_dma; // RQ6 RQ15
                    next_st.equal_turn_dma = !st.equal_turn_dma;
                end else begin
                    next_st.dma_grant = dma_req_i;
                end
            end
            PRIO_DMA_LOWER: begin
                next_st.dma_grant = dma_req_i && !core_req_i; // RQ6 RQ15
            end
            default: begin
                next_st.dma_grant = 1'b0;
            end
        endcase

        next_st.irq = |(irq_status & st.irq_mask);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st <= '0;
            st.ctrl <= CTRL_RESET;
            st.irq_mask <= IRQ_MASK_RESET;
            st.ta_meta <= 1'b1;
            st.ta_sync <= 1'b1;
            st.stop_state <= STOP_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rdata_o = st.rdata;
    assign chip_mode_o = st.ctrl[CHIP_MODE_LSB +: CHIP_MODE_W]; // RQ1
    assign ext_bus_off_o = st.ctrl[EXT_BUS_OFF_BIT]; // RQ2
    assign mem_swap_on_o = st.ctrl[MEM_SWAP_ON_BIT]; // RQ4
    assign burst_on_o = st.ctrl[BURST_ON_BIT]; // RQ7
    assign release_slow_o = st.ctrl[RELEASE_SLOW_BIT]; // RQ9
    assign async_arb_on_o = st.ctrl[ASYNC_ARB_ON_BIT]; // RQ10
    assign stack_ext_on_o = st.ctrl[STACK_EXT_ON_BIT]; // RQ13
    assign stack_ext_space_o = st.ctrl[STACK_EXT_SPACE_BIT]; // RQ14
    assign stack_ext_over_o = over_flag;
    assign stack_ext_wrapped_o = wrap_flag;
    assign stop_busy_o = (st.stop_state == STOP_WAIT);
    assign stop_done_o = st.stop_done;
    assign ta_o = st.ta;
    assign dma_grant_o = st.dma_grant;
    assign irq_o = st.irq;

endmodule

`default_nettype wire

// *** rtl/sticky_flag.sv ***
// Sticky flag: a hardware set holds the bit until a clear; set wins.
`timescale 1ns/1ps
`default_nettype none

module sticky_flag (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic q_o
);

    typedef struct packed {
        logic q;
    } flag_state_t;

    flag_state_t st;
    flag_state_t next_st;

    always_comb begin
        next_st = st;
        if (set_i) begin
            next_st.q = 1'b1;
        end else if (clr_i) begin
            next_st.q = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q_o = st.q;

endmodule

`default_nettype wire

// *** verif/omr_props.sv ***
// Port-level assertions for the operating mode register.
`timescale 1ns/1ps
`default_nettype none

module omr_props
    import omr_pkg::*;
#(
    parameter int STOP_WAIT_LONG = STOP_WAIT_LONG_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic stack_over_evt_i,
    input wire logic stop_exit_i,
    input wire logic dma_req_i,
    input wire logic [CHIP_MODE_W-1:0] chip_mode_o,
    input wire logic ext_bus_off_o,
    input wire logic burst_on_o,
    input wire logic stack_ext_over_o,
    input wire logic stack_ext_wrapped_o,
    input wire logic stop_busy_o,
    input wire logic stop_done_o,
    input wire logic dma_grant_o
);
    logic [17:0] busy_len;
    logic [DATA_W-1:0] wd_q;
    logic ctrl_wr;

    assign ctrl_wr = wr_i && addr_i == ADDR_MODE_CTRL;

    // Length of the current run of busy cycles, checked when busy falls.
    always_ff @(posedge ref_clk_i) begin
        wd_q <= wdata_i;
        if (!rst_n_i || !stop_busy_o) begin
            busy_len <= '0;
        end else begin
            busy_len <= busy_len + 18'h1;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_rdata_idle:
        assert property (!rd_i |=> rdata_o == '0)
        else $error("read data not zero outside a read");
    chk_reserved_zero:
        assert property (rd_i && addr_i == ADDR_MODE_CTRL |=>
            (rdata_o & ~(CTRL_WRITE_MASK | 24'h0c0000)) == '0)
        else $error("reserved control bits read nonzero");
    chk_field_write:
        assert property (ctrl_wr |=> chip_mode_o == wd_q[3:0] &&
            ext_bus_off_o == wd_q[4] && burst_on_o == wd_q[10])
        else $error("field outputs do not follow the write");
    chk_fields_hold:
        assert property (!ctrl_wr |=>
            $stable({chip_mode_o, ext_bus_off_o, burst_on_o}))
        else $error("field outputs changed without a write");
    chk_over_set:
        assert property (stack_over_evt_i |=> stack_ext_over_o)
        else $error("overflow flag not set after event");
    chk_wrap_sticky:
        assert property (stack_ext_wrapped_o &&
            !(ctrl_wr && !wdata_i[STACK_EXT_WRAPPED_BIT]) |=>
            stack_ext_wrapped_o)
        else $error("wrap flag dropped without a clear");
    chk_stop_start:
        assert property (stop_exit_i && !stop_busy_o |=> stop_busy_o)
        else $error("stop delay did not start");
    chk_stop_len:
        assert property ($fell(stop_busy_o) |->
            busy_len == 16 || busy_len == STOP_WAIT_LONG)
        else $error("stop delay has wrong length");
    chk_done_end:
        assert property (stop_done_o |-> $past(stop_busy_o) && !stop_busy_o)
        else $error("stop done not at the end of the delay");
    chk_grant_req:
        assert property (dma_grant_o |-> $past(dma_req_i))
        else $error("grant without a DMA request");

    cov_wrap: cover property (stack_ext_wrapped_o);
    cov_stop: cover property ($fell(stop_busy_o));
    cov_grant: cover property (dma_grant_o);
endmodule

bind operating_mode_register omr_props #(
    .STOP_WAIT_LONG(STOP_WAIT_LONG)
) u_omr_props (
    .ref_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .stack_over_evt_i, .stop_exit_i, .dma_req_i, .chip_mode_o,
    .ext_bus_off_o, .burst_on_o, .stack_ext_over_o, .stack_ext_wrapped_o,
    .stop_busy_o, .stop_done_o, .dma_grant_o
);
`default_nettype wire

// *** verif/operating_mode_register_tb.sv ***
// Self-checking testbench for the operating mode register.
`timescale 1ns/1ps
`default_nettype none

module operating_mode_register_tb
    import omr_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic wr_i = 1'b0, rd_i = 1'b0, stop_exit_i = 1'b0, ta_n_i = 1'b1;
    logic stack_over_evt_i = 1'b0, stack_wrap_evt_i = 1'b0;
    logic [1:0] core_prio_field_i = 2'h1, dma_chan_prio_i = 2'h0;
    logic dma_req_i = 1'b0, core_req_i = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    logic [CHIP_MODE_W-1:0] chip_mode_o;
    logic ext_bus_off_o, mem_swap_on_o, burst_on_o, release_slow_o;
    logic async_arb_on_o, stack_ext_on_o, stack_ext_space_o, ta_o;
    logic stack_ext_over_o, stack_ext_wrapped_o, stop_busy_o, stop_done_o;
    logic dma_grant_o, irq_o;
    int n_errors = 0, checks = 0;

    operating_mode_register #(.STOP_WAIT_LONG(32)) u_operating_mode_register (
        .ref_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .stack_over_evt_i, .stack_wrap_evt_i, .stop_exit_i, .ta_n_i,
        .core_prio_field_i, .dma_chan_prio_i, .dma_req_i, .core_req_i,
        .chip_mode_o, .ext_bus_off_o, .mem_swap_on_o, .burst_on_o,
        .release_slow_o, .async_arb_on_o, .stack_ext_on_o,
        .stack_ext_space_o, .stack_ext_over_o, .stack_ext_wrapped_o,
        .stop_busy_o, .stop_done_o, .ta_o, .dma_grant_o, .irq_o
    );

    always #25 ref_clk_i = ~ref_clk_i;

    task automatic cmp_word(input string what, input logic [DATA_W-1:0] exp,
                            input logic [DATA_W-1:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask

    task automatic rd(input string what, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] exp);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        cmp_word(what, exp, rdata_o);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_fields();
        logic [DATA_W-1:0] pat [2] = '{24'hffffff, 24'h0a5a5a};
        logic [10:0] fld [2] = '{11'h7ff, 11'h548};
        logic [DATA_W-1:0] back [2] = '{24'h113fdf, 24'h001a5a};
        rd("ctrl reset", ADDR_MODE_CTRL, CTRL_RESET);
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_MODE_CTRL, pat[i]);
            cmp_word("fields", {13'h0, fld[i]}, {13'h0, chip_mode_o,
                ext_bus_off_o, mem_swap_on_o, burst_on_o, release_slow_o,
                async_arb_on_o, stack_ext_on_o, stack_ext_space_o});
            rd("ctrl back", ADDR_MODE_CTRL, back[i]);
        end
        wr(4'h9, 24'hffffff);
        rd("unmapped", 4'h9, 24'h0);
        rd("ctrl kept", ADDR_MODE_CTRL, 24'h001a5a);
    endtask

    task automatic t_flags();
        wr(ADDR_IRQ_MASK, 24'h1);
        @(posedge ref_clk_i) stack_over_evt_i <= 1'b1;
        @(posedge ref_clk_i) stack_over_evt_i <= 1'b0;
        stack_wrap_evt_i <= 1'b1;
        @(posedge ref_clk_i) stack_wrap_evt_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        cmp_bit("irq over", 1'b1, irq_o);
        cmp_bit("over flag", 1'b1, stack_ext_over_o);
        cmp_bit("wrap flag", 1'b1, stack_ext_wrapped_o);
        rd("irq status", ADDR_IRQ_STATUS, 24'h3);
        wr(ADDR_MODE_CTRL, 24'h080000);
        cmp_bit("over clear", 1'b0, stack_ext_over_o);
        rd("wrap kept", ADDR_MODE_CTRL, 24'h080000);
        wr(ADDR_IRQ_STATUS, 24'h1);
        @(posedge ref_clk_i);
        #1;
        cmp_bit("irq masked", 1'b0, irq_o);
        wr(ADDR_IRQ_MASK, 24'h2);
        @(posedge ref_clk_i);
        #1;
        cmp_bit("irq wrap", 1'b1, irq_o);
        wr(ADDR_IRQ_STATUS, 24'h2);
        wr(ADDR_MODE_CTRL, 24'h0);
        cmp_bit("wrap clear", 1'b0, stack_ext_wrapped_o);
        cmp_bit("irq clear", 1'b0, irq_o);
    endtask

    task automatic t_stop(input logic [DATA_W-1:0] ctrl, input int n);
        int k;
        wr(ADDR_MODE_CTRL, ctrl);
        @(posedge ref_clk_i) stop_exit_i <= 1'b1;
        @(posedge ref_clk_i) begin
            stop_exit_i <= 1'b0;
            addr_i <= ADDR_STOP_STATUS;
            rd_i <= 1'b1;
        end
        for (k = 1; k <= 100; k++) begin
            @(posedge ref_clk_i);
            rd_i <= 1'b0;
            #1;
            if (k == 1) begin
                cmp_bit("stop busy", 1'b1, stop_busy_o);
                cmp_bit("stop busy read", 1'b1, rdata_o[DATA_W-1]);
            end
            if (stop_done_o === 1'b1) break;
        end
        cmp_word("stop delay", n[23:0], k[23:0]);
        if (k > 100) final_report();
        rd("stop idle", ADDR_STOP_STATUS, 24'h0);
        rd("stop irq", ADDR_IRQ_STATUS, 24'h4);
        wr(ADDR_IRQ_STATUS, 24'h4);
    endtask

    task automatic t_prio(input logic [1:0] m, input logic [1:0] ch,
                          input logic cr, input int exp);
        logic [DATA_W-1:0] sum;
        sum = '0;
        wr(ADDR_MODE_CTRL, {14'h0, m, 8'h0});
        @(posedge ref_clk_i);
        dma_req_i <= 1'b1;
        dma_chan_prio_i <= ch;
        core_req_i <= cr;
        @(posedge ref_clk_i);
        repeat (2) begin
            @(posedge ref_clk_i);
            #1;
            sum = sum + DATA_W'(dma_grant_o);
        end
        cmp_word("grants", exp[23:0], sum);
    endtask

    task automatic t_ack(input logic s, input int exp);
        int k;
        wr(ADDR_MODE_CTRL, {12'h0, s, 11'h0});
        @(posedge ref_clk_i) ta_n_i <= 1'b0;
        for (k = 1; k <= 8; k++) begin
            @(posedge ref_clk_i);
            #1;
            if (ta_o === 1'b1) break;
        end
        cmp_word("ack delay", exp[23:0], k[23:0]);
        if (k > 8) final_report();
        @(posedge ref_clk_i) ta_n_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
    endtask

    initial begin
        repeat (10) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        t_fields();
        t_flags();
        t_stop(24'h000040, 16);
        t_stop(24'h000000, 32);
        t_prio(2'h0, 2'h2, 1'b1, 2);
        t_prio(2'h0, 2'h0, 1'b1, 0);
        t_prio(2'h0, 2'h0, 1'b0, 2);
        t_prio(2'h1, 2'h0, 1'b1, 2);
        t_prio(2'h2, 2'h2, 1'b1, 1);
        t_prio(2'h3, 2'h2, 1'b1, 0);
        t_prio(2'h3, 2'h2, 1'b0, 2);
        t_ack(1'b0, 1);
        t_ack(1'b1, 3);
        final_report();
    end
endmodule
`default_nettype wire
